/* File: rtl/sarseq_pkg.sv */
// Package for the successive-approximation conversion sequencer.
// Assumes a single 20 MHz system clock and an AXI4-Lite register port.
package sarseq_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0]  ADDR_RESULT   = 5'h00;  // Result / vernier code
  localparam logic [4:0]  ADDR_CONTROL  = 5'h04;  // Start, mode
  localparam logic [4:0]  ADDR_STATUS   = 5'h08;  // Sticky events, read only
  localparam logic [4:0]  ADDR_IRQ_EN   = 5'h0C;  // Interrupt enable
  localparam logic [4:0]  ADDR_IRQ_CLR  = 5'h10;  // Write-one clear
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int          CTRL_START_BIT = 0;     // Start pulse
  localparam int          CTRL_SE_BIT    = 1;     // Single-ended select
  localparam logic [11:0] DAC_INIT       = 12'h800; // Octal 4000, MSB only
  localparam logic [7:0]  VERNIER_RESET  = 8'h80; // Midscale, no offset
  localparam logic [11:0] RESULT_RESET   = 12'h000;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ        = 20000000;
  localparam int          TRIAL_NS      = 1000;   // One bit trial interval
  localparam int          SETTLE_NS     = 500;    // Input switch settling
  localparam int          TRIAL_CYC     = (TRIAL_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [7:0]  TRIAL_CNT     = 8'(TRIAL_CYC - 1);
  localparam logic [7:0]  SETTLE_CNT    = 8'(SETTLE_CYC - 1);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_TRACK,
    ST_SETTLE,
    ST_TRIAL
  } sarseq_state_t;

  typedef struct packed {
    logic        track_close;   // Feedback path closed, S/H tracks
    logic        cmp_route;     // Preamp routed to comparator
    logic        mux_enable;    // Selected channel on
    logic        neg_select;    // Negative member of pair on
    logic        auto_zero;     // Input grounded
  } sarseq_front_t;

  typedef struct packed {
    logic        aw_done;
    logic [4:0]  aw_addr;
    logic        w_done;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sarseq_bus_t;

  typedef struct packed {
    sarseq_state_t state;
    logic [7:0]    timer;
    logic [11:0]   sar;
    logic [3:0]    bit_idx;
    logic          single_ended_select;
    logic [11:0]   result;
    logic [7:0]    vernier;
    logic [1:0]    status;    // [0] done, [1] overrun start
    logic [1:0]    irq_en;
    sarseq_front_t front;
    sarseq_bus_t   bus;
    logic          cmp_s1;
    logic          cmp_s2;
  } sarseq_regs_t;
endpackage

/* File: rtl/sarseq_top.sv */
// Conversion sequencer: sample/hold, input switching, SAR stepping,
// result transfer and vernier offset code, behind an AXI4-Lite slave.
// Assumes the comparator output is asynchronous and is synchronised here.
// Overview of operation
// R1: Idle holds the front end in track
// R2: Start opens track, routes preamp to comparator
// R3: Then ground input or select negative channel
// R4: Load feedback code octal 4000 first
// R5: Trial each bit from MSB to LSB
// R6: Latch comparator decision at each trial end
// R7: Positive summing node clears the trial bit
// R8: After LSB copy SAR into result buffer
// R9: Result coding is offset binary
// R10: Write low byte loads vernier code
// R11: Vernier midscale gives zero offset
// R12: Single-ended hold: channels off, auto-zero on
// R13: Set done flag, return to track
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sarseq_top
  import sarseq_pkg::*;
(
  input  wire logic        sys_clk_in,          // 20 MHz clock
  input  wire logic        reset_n_in,          // Async reset, active low
  input  wire logic [4:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [4:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        cmp_positive_in,     // Summing node positive
  output logic [11:0]      dac_code_out,        // Feedback DAC code
  output logic [7:0]       vernier_code_out,    // Vernier offset DAC code
  output logic             track_close_out,     // Feedback to S/H closed
  output logic             cmp_route_out,       // Preamp to comparator
  output logic             mux_enable_out,      // Addressed channel on
  output logic             neg_select_out,      // Negative pair member on
  output logic             auto_zero_out,       // Auto-zero switch on
  output logic             busy_out,            // Conversion in progress
  output logic             irq_out              // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sarseq_regs_t q_r;                            // All registered state
  sarseq_regs_t q_nxt;                          // Next value
  logic         wr_fire;                        // Write address and data held
  logic         rd_fire;                        // Read address taken
  logic         start_req;                      // Software start
  logic         conv_done;                      // LSB trial finished
  logic [11:0]  trial_mask;                     // One-hot bit under trial

  // Bit under trial as a one-hot mask
  assign trial_mask = 12'h001 << q_r.bit_idx;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready_out = !q_r.bus.aw_done && !q_r.bus.bvalid;
  assign s_axi_wready_out  = !q_r.bus.w_done && !q_r.bus.bvalid;
  assign s_axi_arready_out = !q_r.bus.rvalid;
  assign wr_fire = q_r.bus.aw_done && q_r.bus.w_done && !q_r.bus.bvalid;
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign start_req = wr_fire && (q_r.bus.aw_addr == ADDR_CONTROL)
                     && q_r.bus.w_strb[0] && q_r.bus.w_data[CTRL_START_BIT];
  assign conv_done = (q_r.state == ST_TRIAL) && (q_r.timer == 8'h00)
                     && (q_r.bit_idx == 4'h0);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    // Comparator synchroniser
    q_nxt.cmp_s1 = cmp_positive_in;
    q_nxt.cmp_s2 = q_r.cmp_s1;
    // Write channel capture, in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      q_nxt.bus.aw_done = 1'b1;
      q_nxt.bus.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      q_nxt.bus.w_done = 1'b1;
      q_nxt.bus.w_data = s_axi_wdata_in;
      q_nxt.bus.w_strb = s_axi_wstrb_in;
    end
    // Write decode
    if (wr_fire) begin
      q_nxt.bus.aw_done = 1'b0;
      q_nxt.bus.w_done  = 1'b0;
      q_nxt.bus.bvalid  = 1'b1;
      q_nxt.bus.bresp   = 2'h0;
      case (q_r.bus.aw_addr)
        ADDR_RESULT: begin
          if (q_r.bus.w_strb[0]) begin
            q_nxt.vernier = q_r.bus.w_data[7:0];           // R10 R11
          end
        end
        ADDR_CONTROL: begin
          if (q_r.bus.w_strb[0] && q_r.state == ST_TRACK) begin
            q_nxt.single_ended_select = q_r.bus.w_data[CTRL_SE_BIT];
          end
        end
        ADDR_STATUS: begin
          // Read only, write ignored
        end
        ADDR_IRQ_EN: begin
          if (q_r.bus.w_strb[0]) begin
            q_nxt.irq_en = q_r.bus.w_data[1:0];
          end
        end
        ADDR_IRQ_CLR: begin
          if (q_r.bus.w_strb[0]) begin
            q_nxt.status = q_r.status & ~q_r.bus.w_data[1:0];
          end
        end
        default: begin
          q_nxt.bus.bresp = 2'h2;                          // SLVERR
        end
      endcase
    end
    if (q_r.bus.bvalid && s_axi_bready_in) begin
      q_nxt.bus.bvalid = 1'b0;
    end
    // Read decode
    if (rd_fire) begin
      q_nxt.bus.rvalid = 1'b1;
      q_nxt.bus.rresp  = 2'h0;
      q_nxt.bus.rdata  = 32'h0000_0000;
      case (s_axi_araddr_in)
        ADDR_RESULT:  q_nxt.bus.rdata = {20'h0_0000, q_r.result};   // R9
        ADDR_CONTROL: q_nxt.bus.rdata = {30'h0, q_r.single_ended_select, 1'b0};
        ADDR_STATUS:  q_nxt.bus.rdata = {29'h0, q_r.state != ST_TRACK, q_r.status};
        ADDR_IRQ_EN:  q_nxt.bus.rdata = {30'h0, q_r.irq_en};
        ADDR_IRQ_CLR: q_nxt.bus.rdata = 32'h0000_0000;
        default:      q_nxt.bus.rresp = 2'h2;
      endcase
    end else if (q_r.bus.rvalid && s_axi_rready_in) begin
      q_nxt.bus.rvalid = 1'b0;
    end
    // Conversion sequencer
    case (q_r.state)
      ST_TRACK: begin
        q_nxt.front = '{track_close: 1'b1, cmp_route: 1'b0,
                        mux_enable: 1'b1, neg_select: 1'b0, auto_zero: 1'b0}; // R1
        if (start_req) begin
          q_nxt.front.track_close = 1'b0;                  // R2
          q_nxt.front.cmp_route   = 1'b1;                  // R2
          q_nxt.front.mux_enable  = 1'b1;
          q_nxt.sar     = DAC_INIT;                        // R4
          q_nxt.bit_idx = 4'hB;
          q_nxt.timer   = SETTLE_CNT;
          q_nxt.state   = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // Hold: switch the converter input after freezing
        q_nxt.front.mux_enable = 1'b0;                     // R3
        q_nxt.front.auto_zero  = q_r.single_ended_select;  // R3 R12
        q_nxt.front.neg_select = !q_r.single_ended_select; // R3
        if (q_r.timer == 8'h00) begin
          q_nxt.timer = TRIAL_CNT;
          q_nxt.state = ST_TRIAL;
        end else begin
          q_nxt.timer = q_r.timer - 8'h01;
        end
      end
      ST_TRIAL: begin
        if (q_r.timer != 8'h00) begin
          q_nxt.timer = q_r.timer - 8'h01;
        end else begin
          // Positive node rejects the bit under trial
          if (q_r.cmp_s2) begin
            q_nxt.sar = q_r.sar & ~trial_mask;             // R6 R7
          end
          if (q_r.bit_idx == 4'h0) begin
            q_nxt.result = q_r.cmp_s2 ? (q_r.sar & ~trial_mask) : q_r.sar; // R8
            q_nxt.state  = ST_TRACK;                       // R13
            q_nxt.front  = '{track_close: 1'b1, cmp_route: 1'b0,
                             mux_enable: 1'b1, neg_select: 1'b0, auto_zero: 1'b0};
          end else begin
            q_nxt.bit_idx = q_r.bit_idx - 4'h1;            // R5
            q_nxt.sar     = (q_r.cmp_s2 ? (q_r.sar & ~trial_mask) : q_r.sar)
                            | (trial_mask >> 1);           // R5
            q_nxt.timer   = TRIAL_CNT;
          end
        end
      end
      default: begin
        q_nxt.state = ST_TRACK;
      end
    endcase
    // Sticky events: set wins over clear
    if (conv_done) begin
      q_nxt.status[0] = 1'b1;                              // R13
    end
    if (start_req && q_r.state != ST_TRACK) begin
      q_nxt.status[1] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_r <= '{state: ST_TRACK, timer: 8'h00, sar: DAC_INIT, bit_idx: 4'hB,
               single_ended_select: 1'b0, result: RESULT_RESET,
               vernier: VERNIER_RESET, status: 2'h0, irq_en: 2'h0,
               front: '{track_close: 1'b1, cmp_route: 1'b0, mux_enable: 1'b1,
                        neg_select: 1'b0, auto_zero: 1'b0},
               bus: '0, cmp_s1: 1'b0, cmp_s2: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid_out = q_r.bus.bvalid;
  assign s_axi_bresp_out  = q_r.bus.bresp;
  assign s_axi_rvalid_out = q_r.bus.rvalid;
  assign s_axi_rdata_out  = q_r.bus.rdata;
  assign s_axi_rresp_out  = q_r.bus.rresp;
  assign dac_code_out     = q_r.sar;
  assign vernier_code_out = q_r.vernier;
  assign track_close_out  = q_r.front.track_close;
  assign cmp_route_out    = q_r.front.cmp_route;
  assign mux_enable_out   = q_r.front.mux_enable;
  assign neg_select_out   = q_r.front.neg_select;
  assign auto_zero_out    = q_r.front.auto_zero;
  assign busy_out         = q_r.state != ST_TRACK;
  assign irq_out          = |(q_r.status & q_r.irq_en);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_idle_track: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R1
    !busy_out |-> (track_close_out && !cmp_route_out))
    else $error("Idle front end not tracking");
  a_start_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R2
    (start_req && !busy_out) |=> (!track_close_out && cmp_route_out))
    else $error("Start did not freeze sample");
  a_hold_input: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R3
    (q_r.state == ST_SETTLE && $past(q_r.state) == ST_SETTLE)
      |-> (neg_select_out == !q_r.single_ended_select))
    else $error("Hold input switch wrong");
  a_dac_init: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R4
    (start_req && !busy_out) |=> (dac_code_out == 12'h800))
    else $error("Feedback code not initialised");
  a_bit_step: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R5
    (q_r.state == ST_TRIAL && q_r.timer == 8'h00 && q_r.bit_idx != 4'h0)
      |=> (q_r.bit_idx == $past(q_r.bit_idx) - 4'h1))
    else $error("Trial order broken");
  a_reject_bit: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R7
    (q_r.state == ST_TRIAL && q_r.timer == 8'h00 && q_r.cmp_s2 && q_r.bit_idx != 4'h0)
      |=> !dac_code_out[$past(q_r.bit_idx)])
    else $error("Rejected bit kept");
  a_result_copy: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R8
    conv_done |=> (q_r.result == dac_code_out && !busy_out))
    else $error("Result not transferred");
  a_se_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R12
    (q_r.state == ST_TRIAL && q_r.single_ended_select)
      |-> (auto_zero_out && !mux_enable_out))
    else $error("Auto-zero not on in hold");
  a_done_flag: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R13
    conv_done |=> q_r.status[0])
    else $error("Done flag not set");
  a_vernier_wr: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // R10
    (wr_fire && q_r.bus.aw_addr == ADDR_RESULT && q_r.bus.w_strb[0])
      |=> (vernier_code_out == $past(q_r.bus.w_data[7:0])))
    else $error("Vernier code not loaded");
endmodule
`default_nettype wire

/* File: sim/sarseq_analog_model.sv */
// Behavioural analog front end: comparator against a held input level.
// Assumes the sequencer drives the feedback code and the comparator route.
`timescale 1ns/10ps
`default_nettype none
module sarseq_analog_model (
  input  wire logic        sys_clk_in,        // System clock
  input  wire logic [11:0] dac_code_in,       // Feedback DAC code
  input  wire logic        cmp_route_in,      // Preamp routed to comparator
  input  wire logic [11:0] level_in,          // Held input as an ideal code
  output logic             cmp_positive_out   // Summing node positive
);
  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  logic toggle_r = 1'b0;                      // Junk pattern when not routed
  // Output is meaningless while not routed, so it changes every cycle
  always @(posedge sys_clk_in) begin
    toggle_r <= ~toggle_r;
  end
  // Too large a feedback code leaves the node positive
  assign cmp_positive_out = cmp_route_in ? (dac_code_in > level_in) : toggle_r;
endmodule
`default_nettype wire

/* File: sim/test_sar_conversion_sequencer.sv */
// Self-checking bench for the conversion sequencer.
// Assumes the analog model file is compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_sar_conversion_sequencer;
  import sarseq_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awready, wready, bvalid, arready, rvalid, cmp;
  logic [1:0]  bresp, rresp;
  logic [11:0] dac, level = 12'h000;
  logic [7:0]  vern;
  logic        trk, route, mux, neg, az, busy, irq;
  int          miscompares = 0, n_checks = 0;
  sarseq_top uut (.sys_clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .cmp_positive_in(cmp), .dac_code_out(dac),
    .vernier_code_out(vern), .track_close_out(trk), .cmp_route_out(route),
    .mux_enable_out(mux), .neg_select_out(neg), .auto_zero_out(az), .busy_out(busy),
    .irq_out(irq));
  sarseq_analog_model model (.sys_clk_in(clk), .dac_code_in(dac), .cmp_route_in(route),
    .level_in(level), .cmp_positive_out(cmp));
  // Clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Write; ready is sampled at the falling edge, inputs move only at rising edges
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    // Start just after a rising edge, never in the step of a release
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (awvalid || wvalid) begin
      @(negedge clk) begin ta = awready & awvalid; tw = wready & wvalid; end
      @(posedge clk) begin if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0; end
    end
    do @(negedge clk); while (!bvalid);
    check(32'(bresp), 32'(er));
    @(posedge clk) bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    // Start just after a rising edge, never in the step of a release
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge clk) ta = arready;
      @(posedge clk) if (ta) arvalid <= 1'b0;
    end while (!ta);
    do @(negedge clk); while (!rvalid);
    d = rdata; r = rresp;
    @(posedge clk) rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d; logic [1:0] r;
    axi_rd(a, d, r);
    check(d & m, e);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    // Look only at falling edges, where outputs have settled
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      if (busy === lvl) break;
    end
    check(32'(busy), 32'(lvl));
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check(32'({trk, route, mux, neg, az}), 32'h14);
    check(32'(dac), 32'(DAC_INIT));
    check(32'(vern), 32'(VERNIER_RESET));
    check(32'(irq), 32'h0);
  endtask
  task automatic t_convert(input logic [11:0] lv, input logic se);
    int n;
    level <= lv;
    axi_wr(5'(ADDR_CONTROL), {30'h0, se, 1'b1}, 2'h0);
    wait_busy(1'b1);
    check(32'({trk, route}), 32'h1);
    check(32'(dac), 32'(DAC_INIT));
    axi_wr(5'(ADDR_CONTROL), {30'h0, ~se, 1'b1}, 2'h0);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mux !== 1'b0 && n < 50);
    check(32'({mux, az, neg}), {29'h0, 1'b0, se, ~se});
    wait_busy(1'b0);
    check(32'({trk, route, mux, neg, az}), 32'h14);
    rd_chk(5'(ADDR_RESULT), 32'hFFF, 32'(lv));
    rd_chk(5'(ADDR_STATUS), 32'h7, 32'h3);
    rd_chk(5'(ADDR_CONTROL), 32'h2, {30'h0, se, 1'b0});
    axi_wr(5'(ADDR_IRQ_CLR), 32'h3, 2'h0);
  endtask
  task automatic t_vernier;
    axi_wr(5'(ADDR_RESULT), 32'h0000_5A3C, 2'h0);
    check(32'(vern), 32'h3C);
    rd_chk(5'(ADDR_RESULT), 32'hFFF, 32'hA5A);
  endtask
  task automatic t_irq;
    logic [31:0] d; logic [1:0] r;
    axi_wr(5'(ADDR_IRQ_EN), 32'h1, 2'h0);
    level <= 12'h123;
    axi_wr(5'(ADDR_CONTROL), 32'h1, 2'h0);
    wait_busy(1'b1);
    check(32'(irq), 32'h0);
    wait_busy(1'b0);
    @(negedge clk) check(32'(irq), 32'h1);
    axi_wr(5'(ADDR_IRQ_EN), 32'h0, 2'h0);
    check(32'(irq), 32'h0);
    axi_wr(5'(ADDR_IRQ_EN), 32'h1, 2'h0);
    axi_wr(5'(ADDR_IRQ_CLR), 32'h1, 2'h0);
    check(32'(irq), 32'h0);
    rd_chk(5'(ADDR_IRQ_CLR), 32'hFFFF_FFFF, 32'h0);
    axi_wr(5'h14, 32'h1, 2'h2);
    axi_rd(5'h14, d, r);
    check({d[29:0], r}, 32'h2);
  endtask
  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk) t_reset();
    t_convert(12'hFFF, 1'b1);
    t_convert(12'h7FF, 1'b0);
    t_convert(12'h000, 1'b1);
    t_convert(12'hA5A, 1'b0);
    t_vernier();
    t_irq();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
